// *** dual_dac_data_format_regs.sv ***
// Register file and code latching for two 12-bit converters
//
// Contract
// - Each converter has a separate 8-bit read/write low data byte register.
// - Enable bit 7 zero disables the output pin and shuts converter down.
// - Enable bit one makes the converter run and drive its output pin.
// - Control bits 6 to 3 read zero and ignore writes.
// - Format 000: code is high[3:0] then whole low byte.
// - Format 001: code is high[4:0] then low[7:1].
// - Format 010: code is high[5:0] then low[7:2].
// - Format 011: code is high[6:0] then low[7:3].
// - Format 1xx: code is whole high byte then low[7:4].
// - Second converter has own registers and identical enable behaviour.
// - Second converter format field selects the same five placements.
// - Code latches only on high byte write; write low byte first.
// - Latched code is 12 bits, 0x000 to 0xfff.
`include "conv_map.svh"
module dual_dac_data_format_regs (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regWriteData,
  output logic      [7:0]        regReadData,
  output conv_pkg::code_type     conv0Code,
  output conv_pkg::code_type     conv1Code,
  output logic                   conv0_enable,
  output logic                   conv1_enable,
  output logic                   conv0Shutdown,
  output logic                   conv1Shutdown
);

  conv_pkg::data_type    conv0Data;
  conv_pkg::data_type    conv1Data;
  conv_pkg::control_type conv0_control;
  conv_pkg::control_type conv1_control;
  logic [7:0]            next_regReadData;

  // Shared by both converters so the placements cannot drift apart
  function automatic conv_pkg::code_type assemble(
    input logic [7:0] high,
    input logic [7:0] low,
    input conv_pkg::format_type fmt
  );
    conv_pkg::code_type code;
    code = `CONV_CODE_RESET;
    if (fmt[2]) begin
      code = {high, low[7:4]};
    end else begin
      unique case (fmt[1:0])
        2'h0: code = {high[3:0], low};
        2'h1: code = {high[4:0], low[7:1]};
        2'h2: code = {high[5:0], low[7:2]};
        2'h3: code = {high[6:0], low[7:3]};
      endcase
    end
    return code;
  endfunction

  function automatic conv_pkg::control_type toControl(input logic [7:0] d);
    conv_pkg::control_type c;
    c.enable    = d[`CONV_ENABLE_BIT];
    c.formatSel = d[`CONV_FORMAT_MSB:`CONV_FORMAT_LSB];
    return c;
  endfunction

  function automatic logic [7:0] fromControl(input conv_pkg::control_type c);
    logic [7:0] d;
    d = `CONV_REG_RESET;
    d[`CONV_ENABLE_BIT] = c.enable;
    d[`CONV_FORMAT_MSB:`CONV_FORMAT_LSB] = c.formatSel;
    return d & `CONV_CONTROL_MASK;
  endfunction

  // Data bytes hold every bit written, mapped or not
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv0Data <= {`CONV_REG_RESET, `CONV_REG_RESET};
      conv1Data <= {`CONV_REG_RESET, `CONV_REG_RESET};
    end else if (regWrite) begin
      unique case (regAddr)
        `CONV0_DATA_LOW_ADDR:  conv0Data.low  <= regWriteData;
        `CONV0_DATA_HIGH_ADDR: conv0Data.high <= regWriteData;
        `CONV1_DATA_LOW_ADDR:  conv1Data.low  <= regWriteData;
        `CONV1_DATA_HIGH_ADDR: conv1Data.high <= regWriteData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv0_control <= toControl(`CONV_REG_RESET);
      conv1_control <= toControl(`CONV_REG_RESET);
    end else if (regWrite) begin
      if (regAddr == `CONV0_CONTROL_ADDR) begin
        conv0_control <= toControl(regWriteData);
      end
      if (regAddr == `CONV1_CONTROL_ADDR) begin
        conv1_control <= toControl(regWriteData);
      end
    end
  end

  // Format comes from the control value current at the high byte write;
  // a later format change does not re-place the latched code
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv0Code <= `CONV_CODE_RESET;
      conv1Code <= `CONV_CODE_RESET;
    end else if (regWrite) begin
      if (regAddr == `CONV0_DATA_HIGH_ADDR) begin
        conv0Code <= assemble(regWriteData, conv0Data.low,
                              conv0_control.formatSel);
      end
      if (regAddr == `CONV1_DATA_HIGH_ADDR) begin
        conv1Code <= assemble(regWriteData, conv1Data.low,
                              conv1_control.formatSel);
      end
    end
  end

  // Enable and shutdown follow the control write one cycle later
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv0_enable  <= 1'b0;
      conv1_enable  <= 1'b0;
      conv0Shutdown <= 1'b1;
      conv1Shutdown <= 1'b1;
    end else begin
      conv0_enable  <= conv0_control.enable;
      conv0Shutdown <= !conv0_control.enable;
      conv1_enable  <= conv1_control.enable;
      conv1Shutdown <= !conv1_control.enable;
    end
  end

  always_comb begin
    unique case (regAddr)
      `CONV0_DATA_LOW_ADDR:  next_regReadData = conv0Data.low;
      `CONV0_DATA_HIGH_ADDR: next_regReadData = conv0Data.high;
      `CONV0_CONTROL_ADDR:   next_regReadData = fromControl(conv0_control);
      `CONV1_DATA_LOW_ADDR:  next_regReadData = conv1Data.low;
      `CONV1_DATA_HIGH_ADDR: next_regReadData = conv1Data.high;
      `CONV1_CONTROL_ADDR:   next_regReadData = fromControl(conv1_control);
      default:               next_regReadData = `CONV_REG_RESET;
    endcase
  end

  // Registered read data; holds when no read is pending
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      regReadData <= `CONV_REG_RESET;
    end else if (regRead) begin
      regReadData <= next_regReadData;
    end
  end

endmodule // dual_dac_data_format_regs

// *** conv_map.svh ***
// Register offsets, field positions and reset values of the converter block
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH
`define CONV0_DATA_LOW_ADDR  8'hd2
`define CONV0_DATA_HIGH_ADDR 8'hd3
`define CONV0_CONTROL_ADDR   8'hd4
`define CONV1_DATA_LOW_ADDR  8'hd5
`define CONV1_DATA_HIGH_ADDR 8'hd6
`define CONV1_CONTROL_ADDR   8'hd7
`define CONV_ENABLE_BIT      7
`define CONV_FORMAT_MSB      2
`define CONV_FORMAT_LSB      0
`define CONV_CONTROL_MASK    8'h87
`define CONV_REG_RESET       8'h00
`define CONV_CODE_RESET      12'h000
`endif

// *** conv_pkg.sv ***
// Types shared by the dual converter register block
package conv_pkg;
  typedef logic [11:0] code_type;
  typedef logic [2:0]  format_type;
  typedef struct packed {
    logic       enable;
    format_type formatSel;
  } control_type;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } data_type;
endpackage

// *** conv_props.sv ***
// Port assertions for the converter register block
module conv_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWriteData,
  input wire logic [7:0]  regReadData,
  input wire logic [11:0] conv0Code,
  input wire logic [11:0] conv1Code,
  input wire logic        conv0_enable,
  input wire logic        conv1_enable,
  input wire logic        conv0Shutdown,
  input wire logic        conv1Shutdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  shut_inverse_a: assert property (conv0Shutdown != conv0_enable &&
    conv1Shutdown != conv1_enable) else $error("shutdown not inverse");
  en0_follow_a: assert property (regWrite && regAddr == 8'hd4 |->
    ##2 conv0_enable == $past(regWriteData[7], 2)) else $error("en0 bad");
  en1_follow_a: assert property (regWrite && regAddr == 8'hd7 |->
    ##2 conv1_enable == $past(regWriteData[7], 2)) else $error("en1 bad");
  code0_hold_a: assert property (!(regWrite && regAddr == 8'hd3) |=>
    $stable(conv0Code)) else $error("code0 moved");
  code1_hold_a: assert property (!(regWrite && regAddr == 8'hd6) |=>
    $stable(conv1Code)) else $error("code1 moved");
  ctl_unused_a: assert property (regRead && regAddr == 8'hd4 |=>
    regReadData[6:3] == 4'h0) else $error("unused bits set");
  // Unmapped reads must not leak stale data from an earlier read
  unmapped_read_a: assert property (regRead &&
    !(regAddr inside {[8'hd2:8'hd7]}) |=> regReadData == 8'h00)
    else $error("unmapped read");
  rd_hold_a: assert property (!regRead |=> $stable(regReadData))
    else $error("read data moved");
endmodule // conv_props
bind dual_dac_data_format_regs conv_props props (.*);

// *** tb.sv ***
// Self-checking bench for the converter register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset_n = 0, regWrite = 0, regRead = 0;
  logic [7:0]  regAddr = 8'h00, regWriteData = 8'h00, regReadData, b;
  logic [11:0] conv0Code, conv1Code;
  logic        conv0_enable, conv1_enable, conv0Shutdown, conv1Shutdown;
  logic [15:0] hl;
  int          mismatches = 0, total_checks = 0;
  always #2.5 mclk = ~mclk;
  dual_dac_data_format_regs uut (.*);
  task automatic chk(input logic [11:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Strobes drop a full cycle later so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk);
    {regWrite, regAddr, regWriteData} = {1'b1, a, d};
    @(negedge mclk);
    regWrite = 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge mclk);
    {regRead, regAddr} = {1'b1, a};
    @(negedge mclk);
    regRead = 0;
    chk(regReadData, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1;
    for (int a = 'hd2; a < 'hd9; a++) rd(8'(a), 8'h00);
    chk({conv0_enable, conv1_enable, conv0Shutdown, conv1Shutdown}, 4'h3);
    chk(conv0Code | conv1Code, 12'h000);
    $display("reset test done");
    for (int c = 0; c < 2; c++) begin
      b = c ? 8'hd5 : 8'hd2;
      wr(8'(b + 2), 8'hff);
      rd(8'(b + 2), 8'h87);
      chk({conv0_enable, conv0Shutdown, conv1_enable, conv1Shutdown},
          c ? 4'h6 : 4'h9);
      for (int f = 0; f < 8; f++) begin
        hl = 16'hc3a5 ^ {f[7:0], f[7:0]};
        wr(8'(b + 2), 8'(f));
        wr(b, hl[7:0]);
        wr(8'(b + 1), hl[15:8]);
        chk(c ? conv1Code : conv0Code, 12'(hl >> (f[2] ? 4 : f)));
      end
      wr(b, 8'h0f);
      chk(c ? conv1Code : conv0Code, 12'(hl >> 4));
      rd(b, 8'h0f);
    end
    chk({conv0_enable, conv1_enable, conv0Shutdown}, 3'h1);
    $display("format test done");
    wrap_up();
  end
endmodule // tb
